// *** dagr_pkg.sv ***
// Purpose: Constants for the aux DAC, Q gain and timing-fault register slice
// Assumes: Byte-wide registers on a byte address space
// Notes:   Offsets, field positions and reset values live here only
package dagr_pkg;
    // =====================================================================
    // Widths
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned WORD_W = 10;

    // =====================================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_AUX1_CTRL  = 5'h0E;
    localparam logic [ADDR_W-1:0] OFS_QGAIN_LO   = 5'h0F;
    localparam logic [ADDR_W-1:0] OFS_QGAIN_HI   = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_AUX2_LO    = 5'h11;
    localparam logic [ADDR_W-1:0] OFS_AUX2_CTRL  = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_RSVD_FIRST = 5'h13;
    localparam logic [ADDR_W-1:0] OFS_RSVD_LAST  = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ        = 5'h19;
    localparam logic [ADDR_W-1:0] OFS_REVISION   = 5'h1F;

    // =====================================================================
    // Field positions
    localparam int unsigned BIT_SIGN      = 7;
    localparam int unsigned BIT_SINK      = 6;
    localparam int unsigned BIT_PDOWN     = 5;
    localparam int unsigned BIT_QSLEEP    = 7;
    localparam int unsigned BIT_QPDOWN    = 6;
    localparam int unsigned BIT_DATA_ERR  = 7;
    localparam int unsigned BIT_SYNC_ERR  = 6;
    localparam int unsigned BIT_ERR_TYPE  = 4;
    localparam int unsigned BIT_DATA_EN   = 3;
    localparam int unsigned BIT_SYNC_EN   = 2;
    localparam int unsigned BIT_LOOPBACK  = 0;
    localparam int unsigned HI_MSB        = 1;

    // =====================================================================
    // Reset values
    localparam logic [DATA_W-1:0] RST_CTRL    = 8'h00;
    localparam logic [WORD_W-1:0] RST_QGAIN   = 10'h1F9;
    localparam logic [WORD_W-1:0] RST_AUX2    = 10'h000;
    localparam logic [DATA_W-1:0] RD_ZERO     = 8'h00;
    // Revision code: value is arbitrary
    localparam logic [DATA_W-1:0] REVISION_ID = 8'h5A;

    // Access decode states
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_WRITE = 3'b010,
        ACC_READ  = 3'b100
    } dagr_acc_type;
endpackage : dagr_pkg

// *** dagr_regs.sv ***
// Purpose: Aux DAC, Q gain, timing-fault interrupt and revision registers
// Assumes: Serial port front end delivers decoded byte reads and writes
// Notes:   Read data is registered; a read of the interrupt register clears flags
`timescale 1ns/1ps
module dagr_regs (
    input  wire logic                   sys_clk_i,
    input  wire logic                   srst_i,
    // Decoded register access
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [dagr_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [dagr_pkg::DATA_W-1:0] reg_wdata_i,
    output logic      [dagr_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                        reg_rvalid_o,
    // Fault detectors
    input  wire logic                   data_setup_err_i,
    input  wire logic                   data_hold_err_i,
    input  wire logic                   sync_err_i,
    // Sync path
    input  wire logic                   sync_out_i,
    input  wire logic                   sync_pin_i,
    output logic                        sync_in_o,
    // Analog controls and interrupt line
    output logic                        aux_one_neg_leg_o,
    output logic                        aux_one_sink_o,
    output logic                        aux_one_pdown_o,
    output logic      [dagr_pkg::WORD_W-1:0] q_gain_o,
    output logic                        q_sleep_o,
    output logic                        q_pdown_o,
    output logic      [dagr_pkg::WORD_W-1:0] aux_two_level_o,
    output logic                        aux_two_neg_leg_o,
    output logic                        aux_two_sink_o,
    output logic                        aux_two_pdown_o,
    output logic                        irq_o
);
    import dagr_pkg::*;

    // =====================================================================
    // Access decode
    dagr_acc_type acc_kind;
    logic         wr_aux1;
    logic         wr_qlo;
    logic         wr_qhi;
    logic         wr_a2lo;
    logic         wr_a2hi;
    logic         wr_irq;
    logic         rd_irq;

    // Write wins if both strobes rise together
    always_comb begin
        if (reg_wr_i) begin
            acc_kind = ACC_WRITE;
        end else if (reg_rd_i) begin
            acc_kind = ACC_READ;
        end else begin
            acc_kind = ACC_IDLE;
        end
    end

    // Per-register write strobes; reserved offsets match nothing
    // reserved writes ignored
    assign wr_aux1 = (acc_kind == ACC_WRITE) && (reg_addr_i == OFS_AUX1_CTRL);
    assign wr_qlo  = (acc_kind == ACC_WRITE) && (reg_addr_i == OFS_QGAIN_LO);
    assign wr_qhi  = (acc_kind == ACC_WRITE) && (reg_addr_i == OFS_QGAIN_HI);
    assign wr_a2lo = (acc_kind == ACC_WRITE) && (reg_addr_i == OFS_AUX2_LO);
    assign wr_a2hi = (acc_kind == ACC_WRITE) && (reg_addr_i == OFS_AUX2_CTRL);
    assign wr_irq  = (acc_kind == ACC_WRITE) && (reg_addr_i == OFS_IRQ);
    assign rd_irq  = (acc_kind == ACC_READ)  && (reg_addr_i == OFS_IRQ);

    // =====================================================================
    // Aux DAC 1 control bits
    // sign, direction, power-down
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aux_one_neg_leg_o <= RST_CTRL[BIT_SIGN];
            aux_one_sink_o    <= RST_CTRL[BIT_SINK];
            aux_one_pdown_o   <= RST_CTRL[BIT_PDOWN];
        end else if (wr_aux1) begin
            aux_one_neg_leg_o <= reg_wdata_i[BIT_SIGN];
            aux_one_sink_o    <= reg_wdata_i[BIT_SINK];
            aux_one_pdown_o   <= reg_wdata_i[BIT_PDOWN];
        end
    end

    // =====================================================================
    // Q gain word and power controls
    // split ten-bit gain
    dagr_ten_bit_word #(
        .RESET_VAL (RST_QGAIN)
    ) u_qgain (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .wr_lo_i   (wr_qlo),
        .wr_hi_i   (wr_qhi),
        .wdata_i   (reg_wdata_i),
        .word_o    (q_gain_o)
    );

    // Q sleep and power-down sit beside the gain top bits
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            q_sleep_o <= RST_CTRL[BIT_QSLEEP];
            q_pdown_o <= RST_CTRL[BIT_QPDOWN];
        end else if (wr_qhi) begin
            q_sleep_o <= reg_wdata_i[BIT_QSLEEP];
            q_pdown_o <= reg_wdata_i[BIT_QPDOWN];
        end
    end

    // =====================================================================
    // Aux DAC 2 level and control
    // split ten-bit level
    dagr_ten_bit_word #(
        .RESET_VAL (RST_AUX2)
    ) u_aux2 (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .wr_lo_i   (wr_a2lo),
        .wr_hi_i   (wr_a2hi),
        .wdata_i   (reg_wdata_i),
        .word_o    (aux_two_level_o)
    );

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aux_two_neg_leg_o <= RST_CTRL[BIT_SIGN];
            aux_two_sink_o    <= RST_CTRL[BIT_SINK];
            aux_two_pdown_o   <= RST_CTRL[BIT_PDOWN];
        end else if (wr_a2hi) begin
            aux_two_neg_leg_o <= reg_wdata_i[BIT_SIGN];
            aux_two_sink_o    <= reg_wdata_i[BIT_SINK];
            aux_two_pdown_o   <= reg_wdata_i[BIT_PDOWN];
        end
    end

    // =====================================================================
    // Timing-fault interrupt register
    logic data_err_ff;
    logic sync_err_ff;
    logic err_type_ff;
    logic data_en_ff;
    logic sync_en_ff;
    logic loopback_ff;
    logic data_evt;

    assign data_evt = data_setup_err_i | data_hold_err_i;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            data_en_ff  <= RST_CTRL[BIT_DATA_EN];
            sync_en_ff  <= RST_CTRL[BIT_SYNC_EN];
            loopback_ff <= RST_CTRL[BIT_LOOPBACK];
        end else if (wr_irq) begin
            data_en_ff  <= reg_wdata_i[BIT_DATA_EN];
            sync_en_ff  <= reg_wdata_i[BIT_SYNC_EN];
            loopback_ff <= reg_wdata_i[BIT_LOOPBACK];
        end
    end

    // data fault latch, new event beats read clear
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            data_err_ff <= 1'b0;
        end else if (data_evt) begin
            data_err_ff <= 1'b1;
        end else if (rd_irq) begin
            data_err_ff <= 1'b0;
        end
    end

    // sync fault latch, new event beats read clear
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync_err_ff <= 1'b0;
        end else if (sync_err_i) begin
            sync_err_ff <= 1'b1;
        end else if (rd_irq) begin
            sync_err_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            err_type_ff <= 1'b0;
        end else if (data_evt) begin
            err_type_ff <= data_setup_err_i;
        end
    end

    // Masked flags drive the interrupt line
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (data_err_ff & data_en_ff) | (sync_err_ff & sync_en_ff);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync_in_o <= 1'b0;
        end else begin
            sync_in_o <= loopback_ff ? sync_out_i : sync_pin_i;
        end
    end

    // =====================================================================
    // Read-back
    logic [DATA_W-1:0] nxt_rdata;

    always_comb begin
        nxt_rdata = RD_ZERO;
        case (reg_addr_i)
            OFS_AUX1_CTRL: begin
                nxt_rdata[BIT_SIGN]  = aux_one_neg_leg_o;
                nxt_rdata[BIT_SINK]  = aux_one_sink_o;
                nxt_rdata[BIT_PDOWN] = aux_one_pdown_o;
            end
            OFS_QGAIN_LO: begin
                nxt_rdata = q_gain_o[DATA_W-1:0];
            end
            OFS_QGAIN_HI: begin
                nxt_rdata[HI_MSB:0]   = q_gain_o[WORD_W-1:DATA_W];
                nxt_rdata[BIT_QSLEEP] = q_sleep_o;
                nxt_rdata[BIT_QPDOWN] = q_pdown_o;
            end
            OFS_AUX2_LO: begin
                nxt_rdata = aux_two_level_o[DATA_W-1:0];
            end
            OFS_AUX2_CTRL: begin
                nxt_rdata[HI_MSB:0]  = aux_two_level_o[WORD_W-1:DATA_W];
                nxt_rdata[BIT_SIGN]  = aux_two_neg_leg_o;
                nxt_rdata[BIT_SINK]  = aux_two_sink_o;
                nxt_rdata[BIT_PDOWN] = aux_two_pdown_o;
            end
            OFS_IRQ: begin
                nxt_rdata[BIT_DATA_ERR] = data_err_ff;
                nxt_rdata[BIT_SYNC_ERR] = sync_err_ff;
                nxt_rdata[BIT_ERR_TYPE] = err_type_ff;
                nxt_rdata[BIT_DATA_EN]  = data_en_ff;
                nxt_rdata[BIT_SYNC_EN]  = sync_en_ff;
                nxt_rdata[BIT_LOOPBACK] = loopback_ff;
            end
            OFS_REVISION: begin
                nxt_rdata = REVISION_ID;
            end
            default: begin
                nxt_rdata = RD_ZERO;
            end
        endcase
    end

    // Read data captured on the read strobe, held otherwise
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o  <= RD_ZERO;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= (acc_kind == ACC_READ);
            if (acc_kind == ACC_READ) begin
                reg_rdata_o <= nxt_rdata;
            end
        end
    end

    // =====================================================================
    // Checks
    // data fault sets flag
    property p_data_set;
        @(posedge sys_clk_i) disable iff (srst_i)
        data_evt |=> data_err_ff;
    endproperty
    a_data_set: assert property (p_data_set) else $error("data flag not set");

    property p_sync_set;
        @(posedge sys_clk_i) disable iff (srst_i)
        sync_err_i |=> sync_err_ff;
    endproperty
    a_sync_set: assert property (p_sync_set) else $error("sync flag not set");

    // flag only falls after an interrupt read
    property p_hold;
        @(posedge sys_clk_i) disable iff (srst_i)
        $fell(data_err_ff) |-> $past(rd_irq);
    endproperty
    a_hold: assert property (p_hold) else $error("data flag fell without read");

    // read without event clears flag and reports old value
    property p_read_clear;
        @(posedge sys_clk_i) disable iff (srst_i)
        (rd_irq && !sync_err_i && sync_err_ff) |=> (!sync_err_ff && reg_rdata_o[BIT_SYNC_ERR]);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("sync read clear wrong");

    property p_kind;
        @(posedge sys_clk_i) disable iff (srst_i)
        data_evt |=> (err_type_ff == $past(data_setup_err_i));
    endproperty
    a_kind: assert property (p_kind) else $error("fault kind wrong");

    property p_irq;
        @(posedge sys_clk_i) disable iff (srst_i)
        ##1 irq_o == $past((data_err_ff & data_en_ff) | (sync_err_ff & sync_en_ff));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mask wrong");

    property p_loop;
        @(posedge sys_clk_i) disable iff (srst_i)
        loopback_ff |=> (sync_in_o == $past(sync_out_i));
    endproperty
    a_loop: assert property (p_loop) else $error("sync loopback wrong");

    property p_rev;
        @(posedge sys_clk_i) disable iff (srst_i)
        (acc_kind == ACC_READ && reg_addr_i == OFS_REVISION) |=> (reg_rdata_o == REVISION_ID);
    endproperty
    a_rev: assert property (p_rev) else $error("revision read wrong");

    property p_rsvd;
        @(posedge sys_clk_i) disable iff (srst_i)
        (acc_kind == ACC_READ && reg_addr_i >= OFS_RSVD_FIRST && reg_addr_i <= OFS_RSVD_LAST)
            |=> (reg_rdata_o == RD_ZERO);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");

    property p_pd1;
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_aux1 |=> (aux_one_pdown_o == $past(reg_wdata_i[BIT_PDOWN]));
    endproperty
    a_pd1: assert property (p_pd1) else $error("aux one power-down wrong");
endmodule : dagr_regs

// *** dagr_ten_bit_word.sv ***
// Purpose: One 10-bit word split over a low byte and two high bits
// Assumes: Writes arrive as one-cycle strobes per byte
// Notes:   Used for Q gain and aux DAC 2 level
`timescale 1ns/1ps
module dagr_ten_bit_word #(
    parameter logic [9:0] RESET_VAL = 10'h000
) (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic       wr_lo_i,
    input  wire logic       wr_hi_i,
    input  wire logic [7:0] wdata_i,
    output logic      [9:0] word_o
);
    import dagr_pkg::*;

    // Low byte and top two bits update independently
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            word_o <= RESET_VAL;
        end else begin
            if (wr_lo_i) begin
                word_o[DATA_W-1:0] <= wdata_i;
            end
            if (wr_hi_i) begin
                word_o[WORD_W-1:DATA_W] <= wdata_i[HI_MSB:0];
            end
        end
    end
endmodule : dagr_ten_bit_word

// *** test_dac_aux_gain_irq_regs.sv ***
// Purpose: Self-checking bench for the aux DAC, Q gain and fault registers
// Assumes: Inputs change 1 ns after the rising edge; read data lands one cycle later
// Notes:   Bus tasks leave strobes up; idle() drops them between groups
`timescale 1ns/1ps
module test_dac_aux_gain_irq_regs;
    import dagr_pkg::*;

    // =====================================================================
    // Signals
    logic              sys_clk_i        = 1'b0;
    logic              srst_i           = 1'b1;
    logic              reg_wr_i         = 1'b0;
    logic              reg_rd_i         = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i       = 5'h00;
    logic [DATA_W-1:0] reg_wdata_i      = 8'h00;
    logic              data_setup_err_i = 1'b0;
    logic              data_hold_err_i  = 1'b0;
    logic              sync_err_i       = 1'b0;
    logic              sync_out_i       = 1'b0;
    logic              sync_pin_i       = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic              reg_rvalid_o;
    logic              sync_in_o;
    logic              aux_one_neg_leg_o;
    logic              aux_one_sink_o;
    logic              aux_one_pdown_o;
    logic [WORD_W-1:0] q_gain_o;
    logic              q_sleep_o;
    logic              q_pdown_o;
    logic [WORD_W-1:0] aux_two_level_o;
    logic              aux_two_neg_leg_o;
    logic              aux_two_sink_o;
    logic              aux_two_pdown_o;
    logic              irq_o;
    int                n_errors         = 0;
    int                checks_done      = 0;

    // Clock generator, 50 ns period
    always #25 sys_clk_i = ~sys_clk_i;

    // =====================================================================
    // Design under test
    dagr_regs dagr_regs_inst (
        .sys_clk_i        (sys_clk_i),
        .srst_i           (srst_i),
        .reg_wr_i         (reg_wr_i),
        .reg_rd_i         (reg_rd_i),
        .reg_addr_i       (reg_addr_i),
        .reg_wdata_i      (reg_wdata_i),
        .reg_rdata_o      (reg_rdata_o),
        .reg_rvalid_o     (reg_rvalid_o),
        .data_setup_err_i (data_setup_err_i),
        .data_hold_err_i  (data_hold_err_i),
        .sync_err_i       (sync_err_i),
        .sync_out_i       (sync_out_i),
        .sync_pin_i       (sync_pin_i),
        .sync_in_o        (sync_in_o),
        .aux_one_neg_leg_o(aux_one_neg_leg_o),
        .aux_one_sink_o   (aux_one_sink_o),
        .aux_one_pdown_o  (aux_one_pdown_o),
        .q_gain_o         (q_gain_o),
        .q_sleep_o        (q_sleep_o),
        .q_pdown_o        (q_pdown_o),
        .aux_two_level_o  (aux_two_level_o),
        .aux_two_neg_leg_o(aux_two_neg_leg_o),
        .aux_two_sink_o   (aux_two_sink_o),
        .aux_two_pdown_o  (aux_two_pdown_o),
        .irq_o            (irq_o)
    );

    // =====================================================================
    // Helpers
    // Port value compare
    task automatic chk_out(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_out

    // Register read, judged 1 ns after the read edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        reg_wr_i   = 1'b0;
        reg_rd_i   = 1'b1;
        reg_addr_i = a;
        @(posedge sys_clk_i);
        #1;
        chk_out(10'(reg_rvalid_o), 10'h001);
        chk_out(10'(reg_rdata_o), 10'(exp));
    endtask : rd_chk

    // Register write, effective after the edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        reg_rd_i    = 1'b0;
        reg_wr_i    = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        @(posedge sys_clk_i);
        #1;
    endtask : wr

    // Drop both strobes
    task automatic idle();
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
    endtask : idle

    task automatic clk_step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : clk_step

    // One-cycle fault event pulse
    task automatic fault(input logic s, input logic h, input logic y);
        data_setup_err_i = s;
        data_hold_err_i  = h;
        sync_err_i       = y;
        @(posedge sys_clk_i);
        #1;
        data_setup_err_i = 1'b0;
        data_hold_err_i  = 1'b0;
        sync_err_i       = 1'b0;
    endtask : fault

    // =====================================================================
    // Scenarios
    task automatic t_reset();
        chk_out(q_gain_o, RST_QGAIN);
        chk_out(aux_two_level_o, RST_AUX2);
        chk_out(10'({aux_one_neg_leg_o, aux_one_sink_o, aux_one_pdown_o}), 10'h000);
        chk_out(10'({aux_two_neg_leg_o, aux_two_sink_o, aux_two_pdown_o, irq_o}), 10'h000);
        rd_chk(OFS_AUX1_CTRL, RST_CTRL);
        rd_chk(OFS_QGAIN_LO, RST_QGAIN[7:0]);
        rd_chk(OFS_QGAIN_HI, {6'h00, RST_QGAIN[9:8]});
        rd_chk(OFS_AUX2_LO, 8'h00);
        rd_chk(OFS_AUX2_CTRL, 8'h00);
        rd_chk(OFS_IRQ, 8'h00);
        rd_chk(OFS_REVISION, REVISION_ID);
        idle();
        $display("test reset values done");
    endtask : t_reset

    // Each control bit alone on both aux converters
    task automatic t_ctrl();
        for (int i = 5; i < 8; i++) begin
            wr(OFS_AUX1_CTRL, 8'(8'h01 << i));
            chk_out(10'({aux_one_neg_leg_o, aux_one_sink_o, aux_one_pdown_o}), 10'(1 << (i - 5)));
            wr(OFS_AUX2_CTRL, 8'(8'h01 << i));
            chk_out(10'({aux_two_neg_leg_o, aux_two_sink_o, aux_two_pdown_o}), 10'(1 << (i - 5)));
            rd_chk(OFS_AUX1_CTRL, 8'(8'h01 << i));
        end
        wr(OFS_AUX2_CTRL, 8'hFF);
        rd_chk(OFS_AUX2_CTRL, 8'hE3);
        idle();
        $display("test control bits done");
    endtask : t_ctrl

    // Ten-bit words, halves written separately, boundary values
    task automatic t_words();
        wr(OFS_QGAIN_LO, 8'h3C);
        chk_out(q_gain_o, {RST_QGAIN[9:8], 8'h3C});
        wr(OFS_QGAIN_HI, 8'hC2);
        chk_out(q_gain_o, 10'h23C);
        chk_out(10'({q_sleep_o, q_pdown_o}), 10'h003);
        wr(OFS_AUX2_LO, 8'hFF);
        wr(OFS_AUX2_CTRL, 8'h03);
        chk_out(aux_two_level_o, 10'h3FF);
        wr(OFS_AUX2_LO, 8'h00);
        chk_out(aux_two_level_o, 10'h300);
        // Both strobes at once: the write is taken, no read answers
        reg_rd_i    = 1'b1;
        reg_wr_i    = 1'b1;
        reg_addr_i  = OFS_AUX2_LO;
        reg_wdata_i = 8'h5A;
        clk_step(1);
        chk_out(10'(reg_rvalid_o), 10'h000);
        chk_out(aux_two_level_o, 10'h35A);
        rd_chk(OFS_QGAIN_HI, 8'hC2);
        idle();
        $display("test ten-bit words done");
    endtask : t_words

    // Reserved and read-only places
    task automatic t_reserved();
        for (int a = int'(OFS_RSVD_FIRST); a <= int'(OFS_RSVD_LAST); a++) begin
            wr(5'(a), 8'hFF);
        end
        wr(OFS_REVISION, 8'hFF);
        for (int a = int'(OFS_RSVD_FIRST); a <= int'(OFS_RSVD_LAST); a++) begin
            rd_chk(5'(a), RD_ZERO);
        end
        rd_chk(OFS_REVISION, REVISION_ID);
        rd_chk(OFS_AUX2_CTRL, 8'h03);
        idle();
        $display("test reserved space done");
    endtask : t_reserved

    // Flag latching, kinds, clear on read, set winning over clear
    task automatic t_faults();
        wr(OFS_IRQ, 8'hFF);
        rd_chk(OFS_IRQ, 8'h0D);
        wr(OFS_IRQ, 8'h00);
        idle();
        fault(1'b1, 1'b0, 1'b0);
        clk_step(3);
        rd_chk(OFS_IRQ, 8'h90);
        rd_chk(OFS_IRQ, 8'h10);
        idle();
        fault(1'b0, 1'b1, 1'b0);
        rd_chk(OFS_IRQ, 8'h80);
        idle();
        fault(1'b0, 1'b0, 1'b1);
        rd_chk(OFS_IRQ, 8'h40);
        idle();
        fault(1'b1, 1'b1, 1'b0);
        rd_chk(OFS_IRQ, 8'h90);
        fault(1'b1, 1'b0, 1'b0);
        idle();
        rd_chk(OFS_IRQ, 8'h90);
        idle();
        $display("test fault flags done");
    endtask : t_faults

    // Interrupt output with enables and masks
    task automatic t_irq();
        wr(OFS_IRQ, 8'h08);
        idle();
        fault(1'b1, 1'b0, 1'b0);
        chk_out(10'(irq_o), 10'h000);
        clk_step(1);
        chk_out(10'(irq_o), 10'h001);
        fault(1'b0, 1'b0, 1'b1);
        rd_chk(OFS_IRQ, 8'hD8);
        idle();
        clk_step(1);
        chk_out(10'(irq_o), 10'h000);
        fault(1'b0, 1'b0, 1'b1);
        clk_step(2);
        chk_out(10'(irq_o), 10'h000);
        wr(OFS_IRQ, 8'h04);
        idle();
        clk_step(1);
        chk_out(10'(irq_o), 10'h001);
        rd_chk(OFS_IRQ, 8'h54);
        idle();
        fault(1'b1, 1'b0, 1'b0);
        clk_step(2);
        chk_out(10'(irq_o), 10'h000);
        rd_chk(OFS_IRQ, 8'h94);
        idle();
        $display("test interrupt output done");
    endtask : t_irq

    // Sync input source selection
    task automatic t_loop();
        wr(OFS_IRQ, 8'h00);
        idle();
        sync_pin_i = 1'b1;
        clk_step(1);
        chk_out(10'(sync_in_o), 10'h001);
        wr(OFS_IRQ, 8'h01);
        idle();
        clk_step(1);
        chk_out(10'(sync_in_o), 10'h000);
        sync_out_i = 1'b1;
        sync_pin_i = 1'b0;
        clk_step(1);
        chk_out(10'(sync_in_o), 10'h001);
        $display("test sync loopback done");
    endtask : t_loop

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // =====================================================================
    // Main sequence, with a second reset in mid-run
    initial begin
        repeat (12) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        t_reset();
        t_ctrl();
        t_words();
        t_reserved();
        t_faults();
        t_irq();
        t_loop();
        srst_i = 1'b1;
        clk_step(2);
        srst_i = 1'b0;
        sync_out_i = 1'b0;
        t_reset();
        conclude();
    end

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        $display("[ERR] t=%0t watchdog expired", $time);
        conclude();
    end
endmodule : test_dac_aux_gain_irq_regs
